// File: pesd_top.sv
/*
 * Event select and decode with one counter.
 * Software sets code, mask, edge and threshold over AHB-Lite;
 * the selected condition is added to the counter.
 * Assumes all conditions come from hclk logic; run, block-next, data-ready
 * and lock events are qualified by bus_cycle_tick, one pulse per bus cycle.
 */
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module pesd_top
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core state
    input wire logic thermal_trip,
    input wire logic core_halted,
    input wire logic other_core_halted,
    input wire logic bus_cycle_tick,
    // L1 data cache traffic
    input wire logic l1_read,
    input wire logic l1_write,
    input wire logic l1_lock_read,
    input wire logic l1_cacheable,
    input wire logic [1:0] l1_line_state,
    input wire logic l1_replace,
    input wire logic l1_mod_alloc,
    input wire logic l1_mod_evict,
    input wire logic [3:0] l1_miss_outstanding,
    input wire logic dtlb_miss,
    input wire logic prefetch_miss,
    input wire logic [1:0] prefetch_miss_kind,
    input wire logic l1_prefetch_request,
    // Bus unit
    input wire logic [3:0] data_cache_unit_rds,
    input wire logic [3:0] hardware_prefetcher_rds,
    input wire logic block_next_request,
    input wire logic data_ready_strobe,
    input wire logic bus_lock,
    input wire logic bus_lock_this_core,
    input wire logic bus_addr_strobe,
    input wire logic [2:0] bus_txn_kind,
    input wire logic bus_txn_this_core,
    // Counter view
    output logic [31:0] event_count,
    output logic event_selected
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [31:0] sel_q;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic prev_cond_q;
    logic hit_q;

    logic [7:0] ev_code;
    logic [7:0] umask;
    logic [7:0] cmask;
    logic cnt_en;
    logic edge_mode;
    logic [1:0] core_sel;
    logic low_zero;
    logic mesi_hit;
    logic addr_ok;
    logic [7:0] addr_lo;

    assign ev_code = sel_q[pesd_pkg::SEL_EV_LSB +: 8];
    assign umask = sel_q[pesd_pkg::SEL_UM_LSB +: 8];
    assign cmask = sel_q[pesd_pkg::SEL_CMASK_LSB +: 8];
    assign cnt_en = sel_q[pesd_pkg::SEL_EN_BIT];
    assign edge_mode = sel_q[pesd_pkg::SEL_EDGE_BIT];
    assign core_sel = umask[pesd_pkg::UM_CORE_LSB +: 2];
    assign low_zero = (umask[pesd_pkg::UM_CORE_LSB-1:0] == pesd_pkg::UM_LOW_ZERO);
    // Line state picks one bit of the low nibble
    assign mesi_hit = umask[l1_line_state];
    assign addr_lo = haddr[pesd_pkg::ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Event decode

    logic [7:0] weight;
    logic sel_valid;
    logic txn_core_ok;
    logic [4:0] rd_out_sum;
    pesd_pkg::pesd_txn_t txn;

    assign txn = pesd_pkg::pesd_txn_t'(bus_txn_kind);
    assign rd_out_sum = {1'b0, data_cache_unit_rds} + {1'b0, hardware_prefetcher_rds};

    always_comb
    begin
        case (core_sel)
            pesd_pkg::CORE_ALL: txn_core_ok = 1'b1;
            pesd_pkg::CORE_THIS: txn_core_ok = bus_txn_this_core;
            pesd_pkg::CORE_OTHER: txn_core_ok = !bus_txn_this_core;
            default: txn_core_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        weight = 8'h00;
        sel_valid = 1'b0;
        case (ev_code)
            pesd_pkg::EV_THERMAL:
            begin
                sel_valid = (umask == pesd_pkg::UM_THERMAL);
                weight = {7'h00, thermal_trip};
            end
            pesd_pkg::EV_BUS_RUN:
            begin
                if (umask == pesd_pkg::UM_RUN_ALL)
                begin
                    sel_valid = 1'b1;
                    weight = {7'h00, bus_cycle_tick && !core_halted};
                end
                else if (umask == pesd_pkg::UM_RUN_SOLO)
                begin
                    sel_valid = 1'b1;
                    weight = {7'h00, bus_cycle_tick && !core_halted && other_core_halted};
                end
            end
            pesd_pkg::EV_L1_RD,
            pesd_pkg::EV_L1_WR,
            pesd_pkg::EV_L1_LOCK:
            begin
                // Core bits are don't-care; an empty state mask counts nothing
                sel_valid = (umask[pesd_pkg::UM_MESI_W-1:0] != pesd_pkg::UM_MESI_NONE);
                if (ev_code == pesd_pkg::EV_L1_RD)
                    weight = {7'h00, l1_read && l1_cacheable && mesi_hit};
                else if (ev_code == pesd_pkg::EV_L1_WR)
                    weight = {7'h00, l1_write && l1_cacheable && mesi_hit};
                else
                    weight = {7'h00, l1_lock_read && l1_cacheable
                              && l1_line_state == pesd_pkg::LS_INVALID && mesi_hit};
            end
            pesd_pkg::EV_L1_ANY:
            begin
                sel_valid = (umask == pesd_pkg::UM_L1_ANY);
                weight = {6'h00, 2'({1'b0, l1_read} + {1'b0, l1_write})};
            end
            pesd_pkg::EV_L1_CACHE:
            begin
                sel_valid = (umask == pesd_pkg::UM_L1_CACHE);
                weight = {6'h00, 2'({1'b0, l1_read && l1_cacheable}
                                     + {1'b0, l1_write && l1_cacheable})};
            end
            pesd_pkg::EV_L1_REPL:
            begin
                sel_valid = (umask == pesd_pkg::UM_L1_REPL);
                weight = {7'h00, l1_replace};
            end
            pesd_pkg::EV_L1_MALLOC:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {7'h00, l1_mod_alloc};
            end
            pesd_pkg::EV_L1_MEVICT:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {7'h00, l1_mod_evict};
            end
            pesd_pkg::EV_L1_PEND:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {4'h0, l1_miss_outstanding};
            end
            pesd_pkg::EV_DTLB:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {7'h00, dtlb_miss};
            end
            pesd_pkg::EV_PF_MISS:
            begin
                sel_valid = (umask == pesd_pkg::UM_PF_NTA) || (umask == pesd_pkg::UM_PF_L1H)
                            || (umask == pesd_pkg::UM_PF_L2H) || (umask == pesd_pkg::UM_PF_NTS);
                weight = {7'h00, prefetch_miss && prefetch_miss_kind == umask[1:0]};
            end
            pesd_pkg::EV_L1_PREF:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                // Each request pulse counts, a resubmitted request included
                weight = {7'h00, l1_prefetch_request};
            end
            pesd_pkg::EV_BUS_RDOUT:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                // Inputs already exclude ownership reads, writes and fetches
                weight = {3'h0, rd_out_sum};
            end
            pesd_pkg::EV_BLOCK_NEXT:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {7'h00, bus_cycle_tick && block_next_request};
            end
            pesd_pkg::EV_DATA_READY:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {7'h00, bus_cycle_tick && data_ready_strobe};
            end
            pesd_pkg::EV_LOCK:
            begin
                sel_valid = (umask == pesd_pkg::UM_ZERO);
                weight = {7'h00, bus_cycle_tick && bus_lock && bus_lock_this_core};
            end
            pesd_pkg::EV_TX_BRD,
            pesd_pkg::EV_TX_OWN,
            pesd_pkg::EV_TX_IFETCH,
            pesd_pkg::EV_TX_INVAL,
            pesd_pkg::EV_TX_PWR,
            pesd_pkg::EV_TX_PART,
            pesd_pkg::EV_TX_IO:
            begin
                sel_valid = low_zero && (core_sel != pesd_pkg::CORE_NONE);
                // One count per address strobe, so a retry counts again
                if (bus_addr_strobe && txn_core_ok)
                begin
                    case (ev_code)
                        pesd_pkg::EV_TX_BRD:
                            weight = {7'h00, txn == pesd_pkg::TXN_BRD};
                        pesd_pkg::EV_TX_OWN:
                            weight = {7'h00, txn == pesd_pkg::TXN_OWN};
                        pesd_pkg::EV_TX_IFETCH:
                            weight = {7'h00, txn == pesd_pkg::TXN_IFETCH};
                        pesd_pkg::EV_TX_INVAL:
                            weight = {7'h00, txn == pesd_pkg::TXN_INVAL};
                        pesd_pkg::EV_TX_PWR:
                            weight = {7'h00, txn == pesd_pkg::TXN_PWR};
                        pesd_pkg::EV_TX_PART:
                            weight = {7'h00, txn == pesd_pkg::TXN_PWR || txn == pesd_pkg::TXN_PRD
                                      || txn == pesd_pkg::TXN_LWR};
                        default:
                            weight = {7'h00, txn == pesd_pkg::TXN_IO};
                    endcase
                end
            end
            default:
            begin
                weight = 8'h00;
                sel_valid = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold and edge shaping

    logic cond;
    logic [7:0] inc;

    // A threshold gives one count per qualifying cycle
    assign cond = (cmask == pesd_pkg::CMASK_OFF) ? (weight != 8'h00) : (weight >= cmask);

    always_comb
    begin
        if (!sel_valid || !cnt_en)
            inc = 8'h00;
        else if (edge_mode)
            inc = {7'h00, cond && !prev_cond_q};
        else if (cmask != pesd_pkg::CMASK_OFF)
            inc = {7'h00, cond};
        else
            inc = weight;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev_cond_q <= 1'b0;
        else
            prev_cond_q <= sel_valid && cond;
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    logic take;

    assign take = hsel && hready && htrans[pesd_pkg::HTRANS_ACT_BIT];

    always_comb
    begin
        case (addr_lo)
            pesd_pkg::OFF_SEL,
            pesd_pkg::OFF_CNT,
            pesd_pkg::OFF_STAT: addr_ok = (haddr[31:pesd_pkg::ADDR_W] == '0);
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= take && hwrite && addr_ok;
            wr_addr_q <= addr_lo;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else if (take && !hwrite && addr_ok)
        begin
            case (addr_lo)
                pesd_pkg::OFF_SEL: hrdata_q <= sel_q;
                pesd_pkg::OFF_CNT: hrdata_q <= cnt_q;
                default: hrdata_q <= {30'h0000_0000, prev_cond_q, hit_q};
            endcase
        end
        else
            hrdata_q <= 32'h0000_0000;
    end

    // Always ready, always OKAY; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sel_q <= pesd_pkg::SEL_RST;
        else if (wr_pend_q && wr_addr_q == pesd_pkg::OFF_SEL)
            sel_q <= hwdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter; a write replaces this cycle's increment

    always_comb
    begin
        if (wr_pend_q && wr_addr_q == pesd_pkg::OFF_CNT)
            cnt_d = hwdata;
        else
            cnt_d = cnt_q + {24'h00_0000, inc};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= pesd_pkg::CNT_RST;
            hit_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            hit_q <= sel_valid;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign event_count = cnt_q;
    assign event_selected = hit_q;

endmodule

// File: pesd_pkg.sv
/*
 * Constants of the event select block: codes, masks, offsets, fields.
 * Assumes one clock and a 32-bit AHB-Lite bus.
 */
package pesd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Event codes
    localparam logic [7:0] EV_THERMAL = 8'h3B;
    localparam logic [7:0] EV_BUS_RUN = 8'h3C;
    localparam logic [7:0] EV_L1_RD = 8'h40;
    localparam logic [7:0] EV_L1_WR = 8'h41;
    localparam logic [7:0] EV_L1_LOCK = 8'h42;
    localparam logic [7:0] EV_L1_ANY = 8'h43;
    localparam logic [7:0] EV_L1_CACHE = 8'h44;
    localparam logic [7:0] EV_L1_REPL = 8'h45;
    localparam logic [7:0] EV_L1_MALLOC = 8'h46;
    localparam logic [7:0] EV_L1_MEVICT = 8'h47;
    localparam logic [7:0] EV_L1_PEND = 8'h48;
    localparam logic [7:0] EV_DTLB = 8'h49;
    localparam logic [7:0] EV_PF_MISS = 8'h4B;
    localparam logic [7:0] EV_L1_PREF = 8'h4F;
    localparam logic [7:0] EV_BUS_RDOUT = 8'h60;
    localparam logic [7:0] EV_BLOCK_NEXT = 8'h61;
    localparam logic [7:0] EV_DATA_READY = 8'h62;
    localparam logic [7:0] EV_LOCK = 8'h63;
    localparam logic [7:0] EV_TX_BRD = 8'h65;
    localparam logic [7:0] EV_TX_OWN = 8'h66;
    localparam logic [7:0] EV_TX_IFETCH = 8'h68;
    localparam logic [7:0] EV_TX_INVAL = 8'h69;
    localparam logic [7:0] EV_TX_PWR = 8'h6A;
    localparam logic [7:0] EV_TX_PART = 8'h6B;
    localparam logic [7:0] EV_TX_IO = 8'h6C;

    ////////////////////////////////////////////////////////////////////////
    // Unit mask values
    localparam logic [7:0] UM_ZERO = 8'h00;
    localparam logic [7:0] UM_THERMAL = 8'hC0;
    localparam logic [7:0] UM_RUN_ALL = 8'h01;
    localparam logic [7:0] UM_RUN_SOLO = 8'h02;
    localparam logic [7:0] UM_L1_ANY = 8'h01;
    localparam logic [7:0] UM_L1_CACHE = 8'h02;
    localparam logic [7:0] UM_L1_REPL = 8'h0F;
    localparam logic [7:0] UM_PF_NTA = 8'h00;
    localparam logic [7:0] UM_PF_L1H = 8'h01;
    localparam logic [7:0] UM_PF_L2H = 8'h02;
    localparam logic [7:0] UM_PF_NTS = 8'h03;
    // Low nibble: one bit per line state
    localparam int UM_MESI_W = 4;
    localparam logic [3:0] UM_MESI_NONE = 4'h0;
    localparam logic [1:0] LS_INVALID = 2'h0;
    localparam logic [1:0] LS_SHARED = 2'h1;
    localparam logic [1:0] LS_EXCL = 2'h2;
    localparam logic [1:0] LS_MOD = 2'h3;
    // Top two bits: core selection
    localparam int UM_CORE_LSB = 6;
    localparam logic [1:0] CORE_NONE = 2'h0;
    localparam logic [1:0] CORE_THIS = 2'h1;
    localparam logic [1:0] CORE_OTHER = 2'h2;
    localparam logic [1:0] CORE_ALL = 2'h3;
    localparam logic [5:0] UM_LOW_ZERO = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // Transaction kind per address strobe
    typedef enum logic [2:0] {
        TXN_BRD,
        TXN_OWN,
        TXN_IFETCH,
        TXN_INVAL,
        TXN_PWR,
        TXN_PRD,
        TXN_LWR,
        TXN_IO
    } pesd_txn_t;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    localparam logic [7:0] OFF_SEL = 8'h00;
    localparam logic [7:0] OFF_CNT = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam int ADDR_W = 8;
    localparam int SEL_EV_LSB = 0;
    localparam int SEL_UM_LSB = 8;
    localparam int SEL_EN_BIT = 16;
    localparam int SEL_EDGE_BIT = 17;
    localparam int SEL_CMASK_LSB = 24;
    localparam int STAT_HIT_BIT = 0;
    localparam int STAT_ACT_BIT = 1;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [7:0] CMASK_OFF = 8'h00;
    localparam int HTRANS_ACT_BIT = 1;
    localparam int WEIGHT_W = 8;
    localparam int OUTST_W = 4;

endpackage

// File: pesd_checker.sv
/*
 * Port checks on pesd_top, bound below.
 * Assumes hready is the block's own hreadyout.
 */
`timescale 1ns/1ps
module pesd_checker
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr, hwdata, hrdata,
    // Conditions
    input wire logic thermal_trip, dtlb_miss, bus_cycle_tick, block_next_request, bus_addr_strobe,
    input wire logic [3:0] l1_miss_outstanding,
    input wire logic [2:0] bus_txn_kind,
    // Counter view
    input wire logic [31:0] event_count,
    input wire logic event_selected
);
    logic take, steady, wr_sel_q, wr_cnt_q, rd_q;
    logic [31:0] sel_sh_q, sel_old_q;
    assign take = hsel && hready && htrans[pesd_pkg::HTRANS_ACT_BIT];
    // Two equal samples rule out the one-cycle lag of the selection decode
    assign steady = sel_sh_q == sel_old_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_sel_q <= 1'b0;
            wr_cnt_q <= 1'b0;
            rd_q <= 1'b0;
            sel_sh_q <= pesd_pkg::SEL_RST;
            sel_old_q <= pesd_pkg::SEL_RST;
        end
        else
        begin
            wr_sel_q <= take && hwrite && haddr == {24'h0, pesd_pkg::OFF_SEL};
            wr_cnt_q <= take && hwrite && haddr == {24'h0, pesd_pkg::OFF_CNT};
            rd_q <= take && !hwrite;
            sel_sh_q <= wr_sel_q ? hwdata : sel_sh_q;
            sel_old_q <= sel_sh_q;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
    chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata not idle");
    chk_count_write: assert property (wr_cnt_q |=> event_count == $past(hwdata)) else $error("counter write lost");
    chk_hold_invalid: assert property ((!event_selected && !wr_cnt_q) ##1 !event_selected |-> $stable(event_count))
        else $error("count moved");
    chk_tlb_count: assert property (steady && sel_sh_q == 32'h0001_0049 && !wr_cnt_q |=>
        event_count == $past(event_count) + 32'($past(dtlb_miss))) else $error("tlb count");
    chk_pend_sum: assert property (steady && sel_sh_q == 32'h0001_0048 && !wr_cnt_q |=>
        event_count == $past(event_count) + 32'($past(l1_miss_outstanding))) else $error("miss weight");
    chk_block_ticks: assert property (steady && sel_sh_q == 32'h0001_0061 && !wr_cnt_q |=>
        event_count == $past(event_count) + 32'($past(bus_cycle_tick && block_next_request)))
        else $error("block cycles");
    chk_io_strobe: assert property (steady && sel_sh_q == 32'h0001_C06C && !wr_cnt_q |=>
        event_count == $past(event_count) + 32'($past(bus_addr_strobe && bus_txn_kind == pesd_pkg::TXN_IO)))
        else $error("io count");
    chk_thermal_edge: assert property (steady && $past(steady) && sel_sh_q == 32'h0003_C03B && !wr_cnt_q |=>
        event_count == $past(event_count) + 32'($past(thermal_trip) && !$past(thermal_trip, 2)))
        else $error("thermal count");
    cover property (sel_sh_q == 32'h0003_C03B && thermal_trip);
    cover property (sel_sh_q == 32'h0001_C06C && bus_addr_strobe);
    cover property (wr_cnt_q && !event_selected);
endmodule

bind pesd_top pesd_checker pesd_checker_i (.*);

// File: pesd_far_model.sv
/*
 * Random caches and bus unit for pesd_top.
 * Assumes one hclk; outputs idle while active is low.
 */
`timescale 1ns/1ps
module pesd_far_model
(
    // Clock, reset and run control
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic active,
    // Core state and L1 traffic
    output logic thermal_trip, core_halted, other_core_halted, bus_cycle_tick, l1_read, l1_write, l1_lock_read,
    output logic l1_cacheable, l1_replace, l1_mod_alloc, l1_mod_evict, dtlb_miss, prefetch_miss, l1_prefetch_request,
    output logic [1:0] l1_line_state, prefetch_miss_kind,
    output logic [3:0] l1_miss_outstanding, data_cache_unit_rds, hardware_prefetcher_rds,
    // Bus unit
    output logic block_next_request, data_ready_strobe, bus_lock, bus_lock_this_core, bus_addr_strobe,
    output logic bus_txn_this_core,
    output logic [2:0] bus_txn_kind
);
    int seed = 32'hDB32;
    logic [31:0] r1, r2;
    logic [37:0] pv;
    // Strobes may repeat on back-to-back cycles, as a retried issue does
    assign {thermal_trip, core_halted, other_core_halted, l1_read, l1_write, l1_lock_read, l1_cacheable,
        l1_replace, l1_mod_alloc, l1_mod_evict, dtlb_miss, prefetch_miss, l1_prefetch_request, l1_line_state,
        prefetch_miss_kind, l1_miss_outstanding, data_cache_unit_rds, hardware_prefetcher_rds, block_next_request,
        data_ready_strobe, bus_lock, bus_lock_this_core, bus_addr_strobe, bus_txn_this_core, bus_txn_kind} = pv;
    always @(posedge hclk or negedge hresetn)
    begin
        r1 = $random(seed);
        r2 = $random(seed);
        // Bus runs at half the core clock
        bus_cycle_tick <= hresetn && active && !bus_cycle_tick;
        pv <= (hresetn && active) ? {r1, r2[5:0]} : 38'h0;
    end
endmodule

// File: test_perf_event_select_decode.sv
/*
 * Bench for pesd_top: bus tasks, a weight model, a selection table.
 * Assumes pesd_far_model and the bound checker.
 */
`timescale 1ns/1ps
module test_perf_event_select_decode;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, active = 1'b0, prv = 1'b0, ok;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, sel = 32'h0, exp_cnt = 32'h0, rd;
    logic hready, hreadyout, hresp, event_selected;
    logic [31:0] hrdata, event_count;
    logic thermal_trip, core_halted, other_core_halted, bus_cycle_tick, l1_read, l1_write, l1_lock_read;
    logic l1_cacheable, l1_replace, l1_mod_alloc, l1_mod_evict, dtlb_miss, prefetch_miss, l1_prefetch_request;
    logic block_next_request, data_ready_strobe, bus_lock, bus_lock_this_core, bus_addr_strobe, bus_txn_this_core;
    logic [1:0] l1_line_state, prefetch_miss_kind;
    logic [3:0] l1_miss_outstanding, data_cache_unit_rds, hardware_prefetcher_rds;
    logic [2:0] bus_txn_kind;
    int err_total = 0, checks = 0, seed = 32'hDB32, w, c;
    logic [31:0] tbl [$] = '{32'h0001C03B, 32'h0003C03B, 32'h0001013C, 32'h0001023C, 32'h0001033C,
        32'h00010340, 32'h0001C841, 32'h00010F42, 32'h00010040, 32'h00010143, 32'h00010243,
        32'h00010244, 32'h00010044, 32'h00010F45, 32'h00010046, 32'h00010047, 32'h00010048,
        32'h01010048, 32'h00010049, 32'h0001044B, 32'h0001004F, 32'h00010060, 32'h00010061,
        32'h00010062, 32'h00010063, 32'h0001C065, 32'h00014066, 32'h00018068, 32'h0001C069,
        32'h0001C06A, 32'h0001C06B, 32'h0001406C, 32'h0001C06C, 32'h0001006C, 32'h0000C06C};
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    pesd_top pesd_top_i (.*);
    pesd_far_model pesd_far_model_i (.*);
    ////////////////////////////////////////////////////////////////////////
    function automatic int wt(input logic [7:0] ev, input logic [7:0] um);
        logic cf;
        cf = um[7:6] == 2'h3 || (um[7:6] == 2'h1 && bus_txn_this_core) || (um[7:6] == 2'h2 && !bus_txn_this_core);
        case ({ev, um})
            16'h3BC0: return int'(thermal_trip);
            16'h3C01: return int'(bus_cycle_tick && !core_halted);
            16'h3C02: return int'(bus_cycle_tick && !core_halted && other_core_halted);
            16'h4301: return int'(l1_read) + int'(l1_write);
            16'h4402: return l1_cacheable ? int'(l1_read) + int'(l1_write) : 0;
            16'h450F: return int'(l1_replace);
            16'h4600: return int'(l1_mod_alloc);
            16'h4700: return int'(l1_mod_evict);
            16'h4800: return int'(l1_miss_outstanding);
            16'h4900: return int'(dtlb_miss);
            16'h4F00: return int'(l1_prefetch_request);
            16'h6000: return int'(data_cache_unit_rds) + int'(hardware_prefetcher_rds);
            16'h6100: return int'(bus_cycle_tick && block_next_request);
            16'h6200: return int'(bus_cycle_tick && data_ready_strobe);
            16'h6300: return int'(bus_cycle_tick && bus_lock && bus_lock_this_core);
            default: ;
        endcase
        if (ev == 8'h4B && um[7:2] == 6'h00)
            return int'(prefetch_miss && prefetch_miss_kind == um[1:0]);
        if (ev >= 8'h40 && ev <= 8'h42 && um[3:0] != 4'h0)
            return int'(l1_cacheable && um[l1_line_state] && (ev == 8'h40 ? l1_read : ev == 8'h41 ? l1_write
                : l1_lock_read && l1_line_state == 2'h0));
        if (ev inside {8'h65, 8'h66, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C} && um[5:0] == 6'h00 && um[7:6] != 2'h0)
            return int'(bus_addr_strobe && cf && (ev == 8'h6B ? bus_txn_kind inside {3'h4, 3'h5, 3'h6}
                : bus_txn_kind == (ev == 8'h65 ? 3'h0 : ev == 8'h66 ? 3'h1 : ev == 8'h68 ? 3'h2
                : ev == 8'h69 ? 3'h3 : ev == 8'h6A ? 3'h4 : 3'h7)));
        return -1;
    endfunction
    always @(posedge hclk)
    begin
        w = wt(sel[7:0], sel[15:8]);
        if (hresetn && w >= 0)
        begin
            c = (sel[31:24] != 8'h00) ? int'(w >= int'(sel[31:24])) : int'(w != 0);
            exp_cnt = exp_cnt + (sel[16] ? 32'(sel[17] ? int'(c == 1 && !prv) : (sel[31:24] != 8'h00 ? c : w)) : 32'h0);
            prv = c[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            end_of_test();
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    // Rewrite selection only while the far side is quiet
    task run(input logic [31:0] s);
        active <= 1'b0;
        repeat (2) @(posedge hclk);
        ahb(1'b1, pesd_pkg::OFF_SEL, s);
        ahb(1'b1, pesd_pkg::OFF_CNT, 32'h0);
        sel = s;
        exp_cnt = 32'h0;
        prv = 1'b0;
        ok = wt(s[7:0], s[15:8]) >= 0;
        ahb(1'b0, pesd_pkg::OFF_SEL, 32'h0);
        chk(rd, s);
        ahb(1'b0, pesd_pkg::OFF_STAT, 32'h0);
        chk(rd, {31'h0, ok});
        chk({31'h0, event_selected}, {31'h0, ok});
        active <= 1'b1;
        repeat (60) @(posedge hclk);
        active <= 1'b0;
        repeat (3) @(posedge hclk);
        ahb(1'b0, pesd_pkg::OFF_CNT, 32'h0);
        chk(rd, exp_cnt);
    endtask
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, pesd_pkg::OFF_SEL, 32'h0);
        chk(rd, pesd_pkg::SEL_RST);
        ahb(1'b0, pesd_pkg::OFF_CNT, 32'h0);
        chk(rd, pesd_pkg::CNT_RST);
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        foreach (tbl[i])
            run(tbl[i]);
        for (int k = 0; k < 4; k++)
            run({16'h0001, 6'h00, 2'(k), 8'h4B});
        run({5'h00, 3'($random(seed)), 24'h01_0048});
        end_of_test();
    end
endmodule
